// [src/motion_alarm_detector.sv]
// Purpose: alarm detection and excitation control of a positioning driver
// Assumes: motion inputs come from logic on clk; sensor pins are asynchronous
// Notes: first alarm wins; later faults are ignored while one is latched
`include "motion_alarm_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module motion_alarm_detector #(
  parameter int SPEED_W = 16,
  parameter int LINK_W  = 4
) (
  input  wire logic                   clk,
  input  wire logic                   rst_n,
  input  wire logic                   hsel,
  input  wire logic [31:0]            haddr,
  input  wire logic [1:0]             htrans,
  input  wire logic                   hwrite,
  input  wire logic [2:0]             hsize,
  input  wire logic [31:0]            hwdata,
  input  wire logic                   hready,
  output logic                        hreadyout,
  output logic                        hresp,
  output logic [31:0]                 hrdata,
  output logic                        irq,
  input  wire logic                   positive_limit_sensor,
  input  wire logic                   negative_limit_sensor,
  input  wire logic                   home_sensor_input,
  input  wire logic                   step_phase_origin_output,
  input  wire logic                   zero_phase_output,
  input  wire logic                   slot_sensor_input,
  input  wire logic                   alarm_clear_input,
  input  wire logic                   homeActive,
  input  wire logic                   homeDirPos,
  input  wire logic                   homeUsesLimits,
  input  wire logic                   homeThreeSensor,
  input  wire logic                   homeOffsetMove,
  input  wire logic                   homeOriginCheck,
  input  wire logic                   homeEndBad,
  input  wire motion_alarm_pkg::pos_t motorPos,
  input  wire logic                   startReq,
  input  wire logic                   startPositioning,
  input  wire logic [SPEED_W-1:0]     startSpeed,
  input  wire logic [LINK_W-1:0]      linkCount,
  input  wire logic                   linkDirMixed,
  output logic                        startAccept,
  output logic                        motorCurrentEn,
  output logic                        brakeEngage,
  output logic                        alarmActive,
  output motion_alarm_pkg::alarm_code_t alarmCode,
  output motion_alarm_pkg::blink_t    ledBlinks
);
  import motion_alarm_pkg::*;

  alarm_cfg_if cfg ();

  alarm_regs u_regs (
    .clk       (clk),
    .rst_n     (rst_n),
    .hsel      (hsel),
    .haddr     (haddr),
    .htrans    (htrans),
    .hwrite    (hwrite),
    .hsize     (hsize),
    .hwdata    (hwdata),
    .hready    (hready),
    .hreadyout (hreadyout),
    .hresp     (hresp),
    .hrdata    (hrdata),
    .irq       (irq),
    .cfg       (cfg)
  );

  // pin synchronisers: stage one feeds stage two only
  logic [6:0] sync1_r, sync2_r, prev_r;
  logic [6:0] pinRaw;

  assign pinRaw = {alarm_clear_input, slot_sensor_input, zero_phase_output,
                   step_phase_origin_output, home_sensor_input,
                   negative_limit_sensor, positive_limit_sensor};

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sync1_r <= 7'h00;
      sync2_r <= 7'h00;
      prev_r  <= 7'h00;
    end else begin
      sync1_r <= pinRaw;
      sync2_r <= sync1_r;
      prev_r  <= sync2_r;
    end
  end

  logic limPos, limNeg, homeSens, originAny, clrEdge, limRise;

  always_comb begin
    limPos    = sync2_r[0];
    limNeg    = sync2_r[1];
    homeSens  = sync2_r[2];
    originAny = |sync2_r[5:3];
    clrEdge   = sync2_r[6] && !prev_r[6];
    limRise   = (sync2_r[1:0] & ~prev_r[1:0]) != 2'h0;
  end

  // homing observations, dropped when homing ends
  logic seenPos_r, seenPos_nxt, seenNeg_r, seenNeg_nxt;
  logic seenHome_r, seenHome_nxt, seenOrigin_r, seenOrigin_nxt;

  always_comb begin
    seenPos_nxt    = homeActive && (seenPos_r || limPos);
    seenNeg_nxt    = homeActive && (seenNeg_r || limNeg);
    seenHome_nxt   = homeActive && (seenHome_r || homeSens);
    seenOrigin_nxt = homeActive && (seenOrigin_r || originAny);
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      seenPos_r    <= 1'b0;
      seenNeg_r    <= 1'b0;
      seenHome_r   <= 1'b0;
      seenOrigin_r <= 1'b0;
    end else begin
      seenPos_r    <= seenPos_nxt;
      seenNeg_r    <= seenNeg_nxt;
      seenHome_r   <= seenHome_nxt;
      seenOrigin_r <= seenOrigin_nxt;
    end
  end

  logic [8:0] causeVec;
  logic       tooLong;

  always_comb begin
    tooLong  = linkCount > LINK_W'(`LINK_MAX_ENTRIES);
    causeVec = 9'h000;
    causeVec[`CAUSE_GEAR] = (cfg.gearRes < `GEAR_RES_MIN) ||
                            (cfg.gearRes > `GEAR_RES_MAX);
    // homing drives into the limits on purpose, so hardware overtravel is ignored while homing is active
    causeVec[`CAUSE_HW_OT] = cfg.hwOtEn && limRise && !homeActive;
    causeVec[`CAUSE_SW_OT] = cfg.swOtEn &&
                             ((motorPos >= cfg.softPos) || (motorPos <= cfg.softNeg));
    causeVec[`CAUSE_REV_LIMIT] = homeActive && homeUsesLimits && !homeOffsetMove &&
                                 (homeDirPos ? limNeg : limPos);
    causeVec[`CAUSE_OFFSET_LIM] = homeActive && homeOffsetMove && (limPos || limNeg);
    causeVec[`CAUSE_NO_HOME] = homeActive && homeThreeSensor &&
                               seenPos_r && seenNeg_r && !seenHome_r;
    causeVec[`CAUSE_NO_ORIGIN] = homeActive && homeOriginCheck &&
                                 !seenOrigin_r && !originAny;
    causeVec[`CAUSE_HOME_FAIL] = homeEndBad;
    causeVec[`CAUSE_BAD_DATA] = startReq &&
                                (tooLong || linkDirMixed ||
                                 (startPositioning && startSpeed == '0));
  end

  function automatic alarm_code_t pickCode(input logic [8:0] c);
    alarm_code_t code;
    code = `ALM_CODE_BAD_DATA;
    if (c[`CAUSE_GEAR])            code = `ALM_CODE_GEAR;
    else if (c[`CAUSE_HW_OT])      code = `ALM_CODE_HW_OT;
    else if (c[`CAUSE_SW_OT])      code = `ALM_CODE_SW_OT;
    else if (c[`CAUSE_REV_LIMIT])  code = `ALM_CODE_REV_LIMIT;
    else if (c[`CAUSE_OFFSET_LIM]) code = `ALM_CODE_OFFSET_LIM;
    else if (c[`CAUSE_NO_HOME])    code = `ALM_CODE_NO_HOME;
    else if (c[`CAUSE_NO_ORIGIN])  code = `ALM_CODE_NO_ORIGIN;
    else if (c[`CAUSE_HOME_FAIL])  code = `ALM_CODE_HOME_FAIL;
    return code;
  endfunction

  alarm_state_e state_r, state_nxt;
  alarm_code_t  code_r, code_nxt;
  blink_t       blinks_r, blinks_nxt;
  logic         raiseEv, clearEv, excOff;

  always_comb begin
    state_nxt  = state_r;
    code_nxt   = code_r;
    blinks_nxt = blinks_r;
    raiseEv    = 1'b0;
    clearEv    = 1'b0;
    case (state_r)
      ALM_IDLE: begin
        if (causeVec != 9'h000) begin
          raiseEv    = 1'b1;
          state_nxt  = ALM_LATCHED;
          code_nxt   = pickCode(causeVec);
          blinks_nxt = causeVec[`CAUSE_GEAR] || !causeVec[`CAUSE_HW_OT] ?
                       `BLINKS_NONE : `BLINKS_HW_OT;
        end
      end
      ALM_LATCHED: begin
        // gear alarm stays until reset, whatever the clear input does
        if (clrEdge && code_r != `ALM_CODE_GEAR) begin
          clearEv    = 1'b1;
          state_nxt  = ALM_IDLE;
          code_nxt   = 8'h00;
          blinks_nxt = `BLINKS_NONE;
        end
      end
      default: state_nxt = ALM_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r  <= ALM_IDLE;
      code_r   <= 8'h00;
      blinks_r <= `BLINKS_NONE;
    end else begin
      state_r  <= state_nxt;
      code_r   <= code_nxt;
      blinks_r <= blinks_nxt;
    end
  end

  assign excOff         = (state_r == ALM_LATCHED) && (code_r == `ALM_CODE_GEAR);
  assign motorCurrentEn = !excOff;
  assign brakeEngage    = excOff && cfg.brakeFitted;
  // a start that itself carries bad data is refused too
  assign startAccept    = startReq && (state_r == ALM_IDLE) && (causeVec == 9'h000);
  assign alarmActive    = (state_r == ALM_LATCHED);
  assign alarmCode      = code_r;
  assign ledBlinks      = blinks_r;
  assign cfg.alarmActive = alarmActive;
  assign cfg.alarmCode   = code_r;
  assign cfg.excOff      = excOff;
  assign cfg.raiseEv     = raiseEv;
  assign cfg.clearEv     = clearEv;

  sequence sIdleOnly(logic [8:0] c);
    (state_r == ALM_IDLE) && (causeVec == c);
  endsequence

  sequence sLatchedAs(alarm_code_t c);
    alarmActive && (alarmCode == c);
  endsequence

  AST_EXC_OFF: assert property (@(posedge clk) disable iff (!rst_n)
    sIdleOnly(9'h100) |=> sLatchedAs(`ALM_CODE_GEAR) ##0 !motorCurrentEn ##1 !motorCurrentEn)
    else $error("gear alarm did not cut motor current");
  AST_BRAKE: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(excOff) && cfg.brakeFitted |-> brakeEngage)
    else $error("brake not engaged on excitation-off alarm");
  AST_EXC_ON: assert property (@(posedge clk) disable iff (!rst_n)
    alarmActive && (alarmCode != `ALM_CODE_GEAR) |-> motorCurrentEn)
    else $error("excitation-on alarm cut motor current");
  AST_HOME_FAIL: assert property (@(posedge clk) disable iff (!rst_n)
    sIdleOnly(9'h002) |=> sLatchedAs(`ALM_CODE_HOME_FAIL))
    else $error("home end failure not raised as 62h");
  AST_NO_HOME: assert property (@(posedge clk) disable iff (!rst_n)
    sIdleOnly(9'h008) ##0 (seenPos_r && seenNeg_r) |=> sLatchedAs(`ALM_CODE_NO_HOME))
    else $error("missing home sensor not raised as 63h");
  AST_NO_ORIGIN: assert property (@(posedge clk) disable iff (!rst_n)
    sIdleOnly(9'h004) |=> sLatchedAs(`ALM_CODE_NO_ORIGIN))
    else $error("missing origin signal not raised as 64h");
  AST_HW_OT: assert property (@(posedge clk) disable iff (!rst_n)
    sIdleOnly(9'h080) |=> sLatchedAs(`ALM_CODE_HW_OT) ##0 (ledBlinks == `BLINKS_HW_OT))
    else $error("hardware overtravel not raised with seven blinks");
  AST_SW_OT: assert property (@(posedge clk) disable iff (!rst_n)
    (state_r == ALM_IDLE) && cfg.swOtEn && (motorPos >= cfg.softPos) &&
    !causeVec[`CAUSE_HW_OT] && !causeVec[`CAUSE_GEAR] |=> sLatchedAs(`ALM_CODE_SW_OT))
    else $error("software limit not raised as 67h");
  AST_OFFSET: assert property (@(posedge clk) disable iff (!rst_n)
    sIdleOnly(9'h010) |=> sLatchedAs(`ALM_CODE_OFFSET_LIM))
    else $error("limit in offset move not raised as 6ah");
  AST_LINK: assert property (@(posedge clk) disable iff (!rst_n)
    sIdleOnly(9'h001) ##0 (linkCount >= LINK_W'(`LINK_ALARM_COUNT)) |-> !startAccept
    ##1 sLatchedAs(`ALM_CODE_BAD_DATA))
    else $error("long link not raised as 70h");
  AST_REV_LIMIT: assert property (@(posedge clk) disable iff (!rst_n)
    sIdleOnly(9'h020) |=> sLatchedAs(`ALM_CODE_REV_LIMIT))
    else $error("reverse limit not raised as 61h");
  AST_GEAR_STICKY: assert property (@(posedge clk) disable iff (!rst_n)
    sLatchedAs(`ALM_CODE_GEAR) |=> sLatchedAs(`ALM_CODE_GEAR)[*2])
    else $error("gear alarm cleared without reset");
  AST_LATCH: assert property (@(posedge clk) disable iff (!rst_n)
    alarmActive && !clrEdge |=> alarmActive && $stable(alarmCode) && $stable(ledBlinks))
    else $error("latched alarm code changed");
  AST_NO_START: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(alarmActive) |-> !startAccept throughout (alarmActive [*2]))
    else $error("motion start accepted while alarm latched");
endmodule // motion_alarm_detector
`default_nettype wire

// [src/motion_alarm_defines.svh]
// Purpose: constants of the motion alarm detector
// Assumes: 32-bit AHB-Lite register words, byte offsets below
// Notes: codes are the alarm numbers shown to the user
// Contract
// - excitation-off alarm cuts winding current
// - excitation-off alarm engages fitted brake
// - excitation-on alarm keeps winding current
// - abnormal home end raises 62h
// - 3-sensor homing without home raises 63h
// - no origin timing signal raises 64h
// - hardware overtravel raises 66h, seven blinks
// - software limit reached raises 67h
// - limit during home offset raises 6Ah
// - five or more linked entries raise 70h
// - mixed link directions raise 70h
// - positioning start at zero speed raises 70h
// - gear resolution out of range raises 71h
// - opposite limit during homing raises 61h
`ifndef MOTION_ALARM_DEFINES_SVH
`define MOTION_ALARM_DEFINES_SVH

`define ALM_CODE_REV_LIMIT   8'h61
`define ALM_CODE_HOME_FAIL   8'h62
`define ALM_CODE_NO_HOME     8'h63
`define ALM_CODE_NO_ORIGIN   8'h64
`define ALM_CODE_HW_OT       8'h66
`define ALM_CODE_SW_OT       8'h67
`define ALM_CODE_OFFSET_LIM  8'h6a
`define ALM_CODE_BAD_DATA    8'h70
`define ALM_CODE_GEAR        8'h71

`define BLINKS_HW_OT         4'h7
`define BLINKS_NONE          4'h0
`define LINK_MAX_ENTRIES     4
`define LINK_ALARM_COUNT     5

`define CAUSE_GEAR           8
`define CAUSE_HW_OT          7
`define CAUSE_SW_OT          6
`define CAUSE_REV_LIMIT      5
`define CAUSE_OFFSET_LIM     4
`define CAUSE_NO_HOME        3
`define CAUSE_NO_ORIGIN      2
`define CAUSE_HOME_FAIL      1
`define CAUSE_BAD_DATA       0

`define REG_CTRL             8'h00
`define REG_SOFT_POS         8'h04
`define REG_SOFT_NEG         8'h08
`define REG_GEAR_RES         8'h0c
`define REG_ALARM_STAT       8'h10
`define REG_IRQ_STATUS       8'h14
`define REG_IRQ_MASK         8'h18
`define REG_UNMAPPED         8'hff

`define CTRL_HWOT_BIT        0
`define CTRL_SWOT_BIT        1
`define CTRL_BRAKE_BIT       2
`define STAT_ACTIVE_BIT      8
`define STAT_EXCOFF_BIT      9
`define IRQ_RAISE_BIT        0
`define IRQ_CLEAR_BIT        1

`define CTRL_RESET           3'h0
`define SOFT_POS_RESET       32'h7fffffff
`define SOFT_NEG_RESET       32'h80000000
`define GEAR_RES_RESET       16'h03e8
`define GEAR_RES_MIN         16'h0064
`define GEAR_RES_MAX         16'h2710
`define IRQ_RESET            2'h0

`endif

// [src/motion_alarm_pkg.sv]
// Purpose: shared types of the motion alarm detector
// Assumes: nothing beyond the defines header
// Notes: none
package motion_alarm_pkg;
  typedef enum logic {
    ALM_IDLE    = 1'b0,
    ALM_LATCHED = 1'b1
  } alarm_state_e;
  typedef logic [7:0]         alarm_code_t;
  typedef logic [3:0]         blink_t;
  typedef logic signed [31:0] pos_t;
endpackage

// [src/alarm_cfg_if.sv]
// Purpose: settings and alarm status between register file and detector
// Assumes: one clock domain
// Notes: none
`timescale 1ns/1ps
`default_nettype none
interface alarm_cfg_if;
  import motion_alarm_pkg::*;
  logic        hwOtEn;
  logic        swOtEn;
  logic        brakeFitted;
  pos_t        softPos;
  pos_t        softNeg;
  logic [15:0] gearRes;
  logic        alarmActive;
  alarm_code_t alarmCode;
  logic        excOff;
  logic        raiseEv;
  logic        clearEv;
  modport regs (output hwOtEn, swOtEn, brakeFitted, softPos, softNeg, gearRes,
                input alarmActive, alarmCode, excOff, raiseEv, clearEv);
  modport core (input hwOtEn, swOtEn, brakeFitted, softPos, softNeg, gearRes,
                output alarmActive, alarmCode, excOff, raiseEv, clearEv);
endinterface
`default_nettype wire

// [src/alarm_regs.sv]
// Purpose: AHB-Lite register file and interrupt of the alarm detector
// Assumes: zero wait states, word transfers only
// Notes: a read right after a write to the same word returns the old value
`include "motion_alarm_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module alarm_regs (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  output logic             irq,
  alarm_cfg_if.regs        cfg
);
  import motion_alarm_pkg::*;

  logic [2:0]  ctrl_r,    ctrl_nxt;
  pos_t        softPos_r, softPos_nxt;
  pos_t        softNeg_r, softNeg_nxt;
  logic [15:0] gear_r,    gear_nxt;
  logic [1:0]  irqStat_r, irqStat_nxt;
  logic [1:0]  irqMask_r, irqMask_nxt;
  logic        wrPend_r,  wrPend_nxt;
  logic [7:0]  wrAddr_r,  wrAddr_nxt;
  logic [31:0] rdata_r,   rdata_nxt;
  logic        addrPhase;
  logic [7:0]  offs;
  logic [1:0]  w1c;

  always_comb begin
    addrPhase   = hsel && htrans[1] && hready;
    offs        = (haddr[31:8] == 24'h000000) ? haddr[7:0] : `REG_UNMAPPED;
    ctrl_nxt    = ctrl_r;
    softPos_nxt = softPos_r;
    softNeg_nxt = softNeg_r;
    gear_nxt    = gear_r;
    irqMask_nxt = irqMask_r;
    w1c         = 2'h0;
    if (wrPend_r) begin
      case (wrAddr_r)
        `REG_CTRL:       ctrl_nxt    = hwdata[2:0];
        `REG_SOFT_POS:   softPos_nxt = hwdata;
        `REG_SOFT_NEG:   softNeg_nxt = hwdata;
        `REG_GEAR_RES:   gear_nxt    = hwdata[15:0];
        `REG_IRQ_STATUS: w1c         = hwdata[1:0];
        `REG_IRQ_MASK:   irqMask_nxt = hwdata[1:0];
        default:         ctrl_nxt    = ctrl_r;
      endcase
    end
    // set wins over a clear in the same cycle
    irqStat_nxt = (irqStat_r & ~w1c) | {cfg.clearEv, cfg.raiseEv};
    wrPend_nxt  = addrPhase && hwrite && (hsize == 3'h2);
    wrAddr_nxt  = offs;
    rdata_nxt   = rdata_r;
    if (addrPhase && !hwrite) begin
      case (offs)
        `REG_CTRL:       rdata_nxt = {29'h0, ctrl_r};
        `REG_SOFT_POS:   rdata_nxt = softPos_r;
        `REG_SOFT_NEG:   rdata_nxt = softNeg_r;
        `REG_GEAR_RES:   rdata_nxt = {16'h0, gear_r};
        `REG_ALARM_STAT: rdata_nxt = {22'h0, cfg.excOff, cfg.alarmActive, cfg.alarmCode};
        `REG_IRQ_STATUS: rdata_nxt = {30'h0, irqStat_r};
        `REG_IRQ_MASK:   rdata_nxt = {30'h0, irqMask_r};
        default:         rdata_nxt = 32'h0;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_r    <= `CTRL_RESET;
      softPos_r <= `SOFT_POS_RESET;
      softNeg_r <= `SOFT_NEG_RESET;
      gear_r    <= `GEAR_RES_RESET;
      irqStat_r <= `IRQ_RESET;
      irqMask_r <= `IRQ_RESET;
      wrPend_r  <= 1'b0;
      wrAddr_r  <= `REG_UNMAPPED;
      rdata_r   <= 32'h0;
    end else begin
      ctrl_r    <= ctrl_nxt;
      softPos_r <= softPos_nxt;
      softNeg_r <= softNeg_nxt;
      gear_r    <= gear_nxt;
      irqStat_r <= irqStat_nxt;
      irqMask_r <= irqMask_nxt;
      wrPend_r  <= wrPend_nxt;
      wrAddr_r  <= wrAddr_nxt;
      rdata_r   <= rdata_nxt;
    end
  end

  assign hreadyout       = 1'b1;
  assign hresp           = 1'b0;
  assign hrdata          = rdata_r;
  assign irq             = |(irqStat_r & irqMask_r);
  assign cfg.hwOtEn      = ctrl_r[`CTRL_HWOT_BIT];
  assign cfg.swOtEn      = ctrl_r[`CTRL_SWOT_BIT];
  assign cfg.brakeFitted = ctrl_r[`CTRL_BRAKE_BIT];
  assign cfg.softPos     = softPos_r;
  assign cfg.softNeg     = softNeg_r;
  assign cfg.gearRes     = gear_r;
endmodule // alarm_regs
`default_nettype wire

// [sim/sensor_model.sv]
// Purpose: motor side model, limit, home and origin sensors plus shaft hold
// Assumes: bench sets sensor levels right after a rising edge
// Notes: sensor lines are always driven, never released
`timescale 1ns/1ps
`default_nettype none
module sensor_model (
  input  wire logic [5:0] setLv,
  input  wire logic       motorCurrentEn,
  input  wire logic       brakeEngage,
  output logic            positive_limit_sensor,
  output logic            negative_limit_sensor,
  output logic            home_sensor_input,
  output logic            step_phase_origin_output,
  output logic            zero_phase_output,
  output logic            slot_sensor_input,
  output logic            shaftHeld
);
  // order: pos, neg, home, step origin, zero phase, slot
  assign {positive_limit_sensor, negative_limit_sensor, home_sensor_input,
          step_phase_origin_output, zero_phase_output, slot_sensor_input} = setLv;
  // shaft keeps its place while wound or braked
  assign shaftHeld = motorCurrentEn | brakeEngage;
endmodule // sensor_model
`default_nettype wire

// [sim/testbench.sv]
// Purpose: self-checking bench of the motion alarm detector
// Assumes: zero-wait AHB-Lite slave, irq mask open
// Notes: expected alarm codes queue up and are taken off on each raise
`include "motion_alarm_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import motion_alarm_pkg::*;
  logic        clk = 0, rst_n = 0, hsel = 0, hwrite = 0, clr = 0, seenAct = 0;
  logic [31:0] haddr = 0, hwdata = 0, hrdata, rd, rnd;
  logic [1:0]  htrans = 0;
  logic        hreadyout, hresp, irq, startAccept, motorCurrentEn, brakeEngage;
  logic        alarmActive, shaftHeld, pL, nL, hS, sO, zO, sS;
  logic        hAct = 0, hDir = 0, hLim = 0, h3 = 0, hOff = 0, hChk = 0, hBad = 0;
  logic        startReq = 1, startPos = 0, dirMix = 0;
  logic [5:0]  setLv = 0;
  logic [15:0] speed = 16'h0010;
  logic [3:0]  links = 0;
  pos_t        motorPos = 0;
  alarm_code_t alarmCode, expQ[$];
  blink_t      ledBlinks;
  int          miscompares = 0, cmp_count = 0, cycles = 0, seed = 32'h0b7f0f3b;

  always #20 clk = ~clk;

  motion_alarm_detector i_dut (.clk(clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .irq(irq),
    .positive_limit_sensor(pL), .negative_limit_sensor(nL), .home_sensor_input(hS),
    .step_phase_origin_output(sO), .zero_phase_output(zO), .slot_sensor_input(sS),
    .alarm_clear_input(clr), .homeActive(hAct), .homeDirPos(hDir), .homeUsesLimits(hLim),
    .homeThreeSensor(h3), .homeOffsetMove(hOff), .homeOriginCheck(hChk),
    .homeEndBad(hBad), .motorPos(motorPos), .startReq(startReq),
    .startPositioning(startPos), .startSpeed(speed), .linkCount(links),
    .linkDirMixed(dirMix), .startAccept(startAccept), .motorCurrentEn(motorCurrentEn),
    .brakeEngage(brakeEngage), .alarmActive(alarmActive), .alarmCode(alarmCode),
    .ledBlinks(ledBlinks));

  sensor_model i_motor (.setLv(setLv), .motorCurrentEn(motorCurrentEn),
    .brakeEngage(brakeEngage), .positive_limit_sensor(pL), .negative_limit_sensor(nL),
    .home_sensor_input(hS), .step_phase_origin_output(sO), .zero_phase_output(zO),
    .slot_sensor_input(sS), .shaftHeld(shaftHeld));

  task summarize;
    $display("compares %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    cmp_count++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  // entered just after a rising edge, returns just after one
  task bus(input logic w, input logic [31:0] a, input logic [31:0] d);
    haddr <= a;
    hwrite <= w;
    htrans <= 2'h2;
    hsel <= 1'b1;
    do @(posedge clk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hreadyout !== 1'b1);
    rd = hrdata;
    chk({30'h0, hreadyout, hresp}, 32'h00000002, "bus response");
  endtask

  // bounded wait, sampled mid-cycle to stay clear of edge races
  task waitAlarm(input logic lvl);
    int n;
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (alarmActive !== lvl && n < 40);
    chk(alarmActive, lvl, "alarm level");
  endtask

  task raise(input alarm_code_t code);
    expQ.push_back(code);
    waitAlarm(1'b1);
    repeat (3) @(negedge clk);
    chk(alarmCode, code, "code held");
    chk(startAccept, 1'b0, "start refused");
    chk(shaftHeld, 1'b1, "shaft held");
    if (code != `ALM_CODE_GEAR) chk(motorCurrentEn, 1'b1, "current kept");
    @(posedge clk);
    $display("test alarm %h done", code);
  endtask

  // drop every cause, then pulse the clear pin
  task clear;
    setLv <= 6'h00;
    {hAct, hDir, hLim, h3, hOff, dirMix, startPos} <= 7'h00;
    links <= 4'h0;
    speed <= 16'h0010;
    motorPos <= 0;
    repeat (3) @(posedge clk);
    clr <= 1'b1;
    waitAlarm(1'b0);
    @(posedge clk);
    clr <= 1'b0;
    @(posedge clk);
  endtask

  always @(negedge clk) begin
    if (alarmActive === 1'b1 && !seenAct) begin
      if (expQ.size() == 0) chk(1, 0, "unexpected alarm");
      else chk(alarmCode, expQ.pop_front(), "alarm code");
    end
    seenAct <= (alarmActive === 1'b1);
  end

  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      summarize();
    end
  end

  initial begin
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    bus(1'b0, `REG_GEAR_RES, 0);
    chk(rd, 32'h000003e8, "gear reset");
    bus(1'b0, `REG_SOFT_NEG, 0);
    chk(rd, `SOFT_NEG_RESET, "neg limit reset");
    bus(1'b0, 32'h0000001c, 0);
    chk(rd, 32'h0, "unmapped read");
    bus(1'b1, `REG_CTRL, 32'h7);
    bus(1'b1, `REG_IRQ_MASK, 32'h3);
    hBad <= 1'b1;
    @(posedge clk);
    hBad <= 1'b0;
    raise(`ALM_CODE_HOME_FAIL);
    chk(irq, 1'b1, "irq raised");
    bus(1'b1, `REG_IRQ_MASK, 32'h0);
    @(negedge clk);
    chk(irq, 1'b0, "irq masked");
    @(posedge clk);
    bus(1'b1, `REG_IRQ_MASK, 32'h3);
    clear();
    bus(1'b1, `REG_IRQ_STATUS, 32'h3);
    @(negedge clk);
    chk(irq, 1'b0, "irq cleared");
    @(posedge clk);
    {hAct, hChk} <= 2'h3;
    @(posedge clk);
    hChk <= 1'b0;
    raise(`ALM_CODE_NO_ORIGIN);
    clear();
    {hAct, hLim, hDir} <= 3'h7;
    setLv <= 6'h10;
    raise(`ALM_CODE_REV_LIMIT);
    clear();
    {hAct, hLim, hDir, hOff} <= 4'hf;
    setLv <= 6'h20;
    raise(`ALM_CODE_OFFSET_LIM);
    clear();
    {hAct, hLim, hDir, h3} <= 4'hf;
    setLv <= 6'h20;
    repeat (4) @(posedge clk);
    setLv <= 6'h00;
    repeat (4) @(posedge clk);
    hDir <= 1'b0;
    setLv <= 6'h10;
    raise(`ALM_CODE_NO_HOME);
    clear();
    for (int i = 0; i < 2; i++) begin
      setLv <= (i == 0) ? 6'h20 : 6'h10;
      raise(`ALM_CODE_HW_OT);
      chk(ledBlinks, `BLINKS_HW_OT, "blinks");
      clear();
    end
    rnd = ($random(seed) & 32'h000fffff) | 32'h00000001;
    bus(1'b1, `REG_SOFT_POS, rnd);
    motorPos <= rnd;
    raise(`ALM_CODE_SW_OT);
    clear();
    motorPos <= `SOFT_NEG_RESET;
    raise(`ALM_CODE_SW_OT);
    clear();
    {startPos, links} <= {1'b1, 4'h4};
    repeat (2) @(negedge clk);
    chk(startAccept, 1'b1, "four links accepted");
    @(posedge clk);
    for (int j = 0; j < 3; j++) begin
      if (j == 0) links <= 4'h5;
      if (j == 1) dirMix <= 1'b1;
      if (j == 2) {startPos, speed} <= {1'b1, 16'h0000};
      raise(`ALM_CODE_BAD_DATA);
      clear();
    end
    bus(1'b1, `REG_GEAR_RES, 32'h00000063);
    raise(`ALM_CODE_GEAR);
    chk(motorCurrentEn, 1'b0, "current cut");
    chk(brakeEngage, 1'b1, "brake on");
    bus(1'b0, `REG_ALARM_STAT, 0);
    chk(rd, 32'h00000371, "alarm status");
    bus(1'b1, `REG_GEAR_RES, 32'h000003e8);
    clr <= 1'b1;
    repeat (10) @(negedge clk);
    chk(alarmActive, 1'b1, "gear alarm kept");
    @(posedge clk);
    {clr, rst_n} <= 2'h0;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    @(negedge clk);
    chk(alarmActive, 1'b0, "cleared by power cycle");
    $display("test power cycle done");
    summarize();
  end
endmodule // testbench
`default_nettype wire
